// >>> verilog/bi_params.svh
/*
 * constants for the four-source bus interrupter: register indices, control
 * field positions, reset values and bus answer codes.
 * assumes inclusion by bare name from the design modules and the testbench.
 */
`ifndef BI_PARAMS_SVH
`define BI_PARAMS_SVH

// register indices (byte address = 4 * index)
`define BI_IDX_CTRL0 3'h0
`define BI_IDX_CTRL1 3'h1
`define BI_IDX_CTRL2 3'h2
`define BI_IDX_CTRL3 3'h3
`define BI_IDX_VEC0 3'h4
`define BI_IDX_VEC3 3'h7
`define BI_ADDR_LSB 2
`define BI_ADDR_W 5

// control register fields
`define BI_LVL_LSB 0
`define BI_LVL_MSB 2
`define BI_BIT_ENA_CLR 3
`define BI_BIT_ENA 4
`define BI_BIT_EXT 5
`define BI_BIT_FLAG_CLR 6
`define BI_BIT_FLAG 7

// reset values
`define BI_CTRL_RST 8'h00
`define BI_VEC_RST 8'h0F

// read data loaded into the bus slave at reset
`define BI_UNMAPPED_DATA 32'h0000_0000

`endif

// >>> verilog/bi_pkg.sv
/*
 * types shared by the bus interrupter modules.
 * assumes bi_params.svh on the include path.
 */
package bi_pkg;
    typedef logic [2:0] bi_level_t;
    typedef logic [7:0] bi_byte_t;
    typedef enum logic [1:0] {
        BI_ACK_IDLE,
        BI_ACK_DECIDE,
        BI_ACK_ANSWER,
        BI_ACK_PASS
    } bi_ack_state_e;
endpackage

// >>> verilog/bi_wb_slave.sv
/*
 * classic wishbone slave for the eight byte-wide interrupter registers.
 * one wait state: ack rises the cycle after stb and drops next cycle.
 * assumes a single-cycle classic master holding its request until ack.
 */
`timescale 1ns/1ps
`include "bi_params.svh"

module bi_wb_slave
    import bi_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [`BI_ADDR_W-1:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    input wire logic [63:0] reg_image_in,
    output logic wb_ack_out,
    output logic [31:0] wb_dat_out,
    output logic wr_stb_out,
    output logic [2:0] wr_idx_out,
    output logic [7:0] wr_data_out
);
    logic ack;
    logic [31:0] rdata;
    logic next_ack;
    logic [31:0] next_rdata;
    logic req;
    logic [2:0] idx;

    assign req = wb_cyc_in & wb_stb_in;
    assign idx = wb_adr_in[`BI_ADDR_LSB +: 3];

    always_comb begin
        next_ack = req & ~ack;
        next_rdata = rdata;
        if (req & ~ack) begin
            next_rdata = {24'h000000, reg_image_in[idx*8 +: 8]};
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            ack <= 1'b0;
            rdata <= `BI_UNMAPPED_DATA;
        end else begin
            ack <= next_ack;
            rdata <= next_rdata;
        end
    end

    // write lands on the acking edge; only lane 0 carries a register
    assign wr_stb_out = req & ack & wb_we_in & wb_sel_in[0];
    assign wr_idx_out = idx;
    assign wr_data_out = wb_dat_in[7:0];
    assign wb_ack_out = ack;
    assign wb_dat_out = rdata;
endmodule

// >>> verilog/bi_level_match.sv
/*
 * per-source request level decode and acknowledge match search.
 * the lowest-numbered source wins when several match the acknowledged level.
 */
`timescale 1ns/1ps
`include "bi_params.svh"

module bi_level_match
    import bi_pkg::*;
(
    input wire logic [3:0] active_in,
    input wire logic [11:0] levels_in,
    input wire logic [2:0] ack_level_in,
    output logic [7:1] irq_level_out,
    output logic hit_out,
    output logic [1:0] hit_index_out
);
    function automatic logic [7:0] lvl_onehot(input logic [2:0] lvl);
        lvl_onehot = 8'h01 << lvl;
    endfunction

    logic [7:0] req_map [4];
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_src
            assign req_map[g] = active_in[g] ? lvl_onehot(levels_in[g*3 +: 3]) : 8'h00;
        end
    endgenerate

    logic [7:0] all_req;
    assign all_req = req_map[0] | req_map[1] | req_map[2] | req_map[3];
    // level 0 never requests
    assign irq_level_out = all_req[7:1];

    always_comb begin
        hit_out = 1'b0;
        hit_index_out = 2'h0;
        for (int i = 3; i >= 0; i--) begin
            if ((req_map[i] & lvl_onehot(ack_level_in) & 8'hFE) != 8'h00) begin
                hit_out = 1'b1;
                hit_index_out = 2'(i);
            end
        end
    end
endmodule

// >>> verilog/bi_core.sv
/*
 * four-source bus interrupter: register file, bus request drive and the
 * interrupt acknowledge responder with daisy chain.
 * assumes acknowledge is already qualified with address and data strobes and
 * all bus-side inputs are synchronous to ref_clk_in.
 */
`timescale 1ns/1ps
`include "bi_params.svh"

// Overview of operation
// [RQ1] low acknowledge input starts acknowledge cycle
// [RQ2] compare address level with requested levels
// [RQ3] chain in low: answer on match, else pass
// [RQ4] wait for chain in; keep chain out negated
// [RQ5] request outputs pulled low, released otherwise
// [RQ6] peripherals drive active-low device interrupt inputs
// [RQ7] acknowledge-enable low marks index valid
// [RQ8] index outputs carry acknowledged source number
// [RQ9] external vector device uses enable and index
// [RQ10] chip select with acknowledge resets device
// [RQ11] eight registers: four control, four vector
// [RQ12] control register n governs input n
// [RQ13] low three bits set request level
// [RQ14] register select and control bit layout
// [RQ15] vector register returned on internal answer
// [RQ16] all sequencing from the single clock
// [RQ17] level zero disables, one to seven select
// [RQ18] bit 4 enables the bus request
// [RQ19] bit 3 clears enable on acknowledge
// [RQ20] bit 5 selects internal or external answer
// [RQ21] reset: controls zero, vectors default value
// [RQ22] bit 7 free flag; bit 6 auto-clears it
module bi_core
    import bi_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [`BI_ADDR_W-1:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic wb_ack_out,
    output logic [31:0] wb_dat_out,
    input wire logic [3:0] device_irq_n_in,
    input wire logic chip_select_n_in,
    input wire logic iack_n_in,
    input wire logic [3:1] iack_level_in,
    input wire logic chain_in_n_in,
    output logic chain_out_n_out,
    output logic [7:1] bus_irq_out,
    output logic [7:1] bus_irq_oe_out,
    output logic [7:0] vector_out,
    output logic vector_oe_out,
    output logic dtack_n_out,
    output logic ack_index_valid_n,
    output logic ack_index_bit0,
    output logic ack_index_bit1
);
    bi_byte_t ctrl [4];
    bi_byte_t vec [4];
    bi_byte_t next_ctrl [4];
    bi_byte_t next_vec [4];
    bi_ack_state_e state;
    bi_ack_state_e next_state;
    logic [1:0] ack_src;
    logic [1:0] next_ack_src;
    logic [7:0] vdata;
    logic [7:0] next_vdata;
    logic chain_out_n;
    logic next_chain_out_n;
    logic self_reset;

    logic wr_stb;
    logic [2:0] wr_idx;
    logic [7:0] wr_data;
    logic [63:0] reg_image;
    logic [3:0] active;
    logic [11:0] levels;
    logic [7:1] irq_level;
    logic hit;
    logic [1:0] hit_index;

    // internal reset from chip select plus acknowledge; see [RQ10]
    assign self_reset = rst_in | (~chip_select_n_in & ~iack_n_in);

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_map
            assign reg_image[g*8 +: 8] = ctrl[g];
            assign reg_image[32 + g*8 +: 8] = vec[g];
            // source g requests when its input is low and enabled; see [RQ12] [RQ18]
            assign active[g] = ~device_irq_n_in[g] & ctrl[g][`BI_BIT_ENA];
            assign levels[g*3 +: 3] = ctrl[g][`BI_LVL_MSB:`BI_LVL_LSB]; // see [RQ13]
        end
    endgenerate

    bi_wb_slave u_bus (
        .ref_clk_in(ref_clk_in),
        .rst_in(self_reset),
        .wb_cyc_in(wb_cyc_in),
        .wb_stb_in(wb_stb_in),
        .wb_we_in(wb_we_in),
        .wb_adr_in(wb_adr_in),
        .wb_sel_in(wb_sel_in),
        .wb_dat_in(wb_dat_in),
        .reg_image_in(reg_image),
        .wb_ack_out(wb_ack_out),
        .wb_dat_out(wb_dat_out),
        .wr_stb_out(wr_stb),
        .wr_idx_out(wr_idx),
        .wr_data_out(wr_data)
    );

    // level zero yields no request; see [RQ17] [RQ2]
    bi_level_match u_match (
        .active_in(active),
        .levels_in(levels),
        .ack_level_in(iack_level_in),
        .irq_level_out(irq_level),
        .hit_out(hit),
        .hit_index_out(hit_index)
    );

    // acknowledge sequencer
    always_comb begin
        next_state = state;
        next_ack_src = ack_src;
        next_vdata = vdata;
        next_chain_out_n = 1'b1;
        case (state)
            BI_ACK_IDLE: begin
                if (~iack_n_in) begin
                    next_state = BI_ACK_DECIDE; // see [RQ1]
                end
            end
            BI_ACK_DECIDE: begin
                if (iack_n_in) begin
                    next_state = BI_ACK_IDLE;
                end else if (~chain_in_n_in) begin // see [RQ4]
                    if (hit) begin
                        next_state = BI_ACK_ANSWER; // see [RQ3]
                        next_ack_src = hit_index;
                        next_vdata = vec[hit_index]; // see [RQ15]
                    end else begin
                        next_state = BI_ACK_PASS;
                        next_chain_out_n = 1'b0; // see [RQ3]
                    end
                end
            end
            BI_ACK_ANSWER: begin
                if (iack_n_in) begin
                    next_state = BI_ACK_IDLE;
                end
            end
            BI_ACK_PASS: begin
                if (iack_n_in) begin
                    next_state = BI_ACK_IDLE;
                end else begin
                    next_chain_out_n = chain_in_n_in;
                end
            end
            default: begin
                next_state = BI_ACK_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (self_reset) begin
            state <= BI_ACK_IDLE;
            ack_src <= 2'h0;
            vdata <= 8'h00;
            chain_out_n <= 1'b1;
        end else begin
            state <= next_state;
            ack_src <= next_ack_src;
            vdata <= next_vdata;
            chain_out_n <= next_chain_out_n;
        end
    end

    logic answering;
    logic entering_answer;
    assign answering = (state == BI_ACK_ANSWER);
    assign entering_answer = (state == BI_ACK_DECIDE) & (next_state == BI_ACK_ANSWER);

    // register file with acknowledge side effects
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            next_ctrl[i] = ctrl[i];
            next_vec[i] = vec[i];
            if (wr_stb && wr_idx == 3'(i)) begin // see [RQ11] [RQ14]
                next_ctrl[i] = wr_data;
            end
            if (wr_stb && wr_idx == 3'(i + 4)) begin
                next_vec[i] = wr_data;
            end
            // acknowledge clears win over a same-cycle write
            if (entering_answer && hit_index == 2'(i)) begin
                if (ctrl[i][`BI_BIT_ENA_CLR]) begin
                    next_ctrl[i][`BI_BIT_ENA] = 1'b0; // see [RQ19]
                end
                if (ctrl[i][`BI_BIT_FLAG_CLR]) begin
                    next_ctrl[i][`BI_BIT_FLAG] = 1'b0; // see [RQ22]
                end
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (self_reset) begin
            for (int i = 0; i < 4; i++) begin
                ctrl[i] <= `BI_CTRL_RST; // see [RQ21]
                vec[i] <= `BI_VEC_RST;
            end
        end else begin
            for (int i = 0; i < 4; i++) begin
                ctrl[i] <= next_ctrl[i];
                vec[i] <= next_vec[i];
            end
        end
    end

    // open-collector style: drive low only while requesting; see [RQ5] [RQ16]
    assign bus_irq_out = 7'h00;
    assign bus_irq_oe_out = irq_level;

    // internal answer only when external bit clear; see [RQ20]
    logic internal_answer;
    assign internal_answer = answering & ~ctrl[ack_src][`BI_BIT_EXT];
    assign vector_out = vdata;
    assign vector_oe_out = internal_answer;
    assign dtack_n_out = ~internal_answer;

    // index valid for the whole answer, external devices rely on it; see [RQ7] [RQ8] [RQ9]
    assign ack_index_valid_n = ~answering;
    assign ack_index_bit0 = ack_src[0];
    assign ack_index_bit1 = ack_src[1];
    assign chain_out_n_out = chain_out_n; // see [RQ4]

    // acknowledge steps shared by the sequence-built checks
    sequence s_ack_open;
        state == BI_ACK_IDLE && !iack_n_in;
    endsequence

    sequence s_ack_match;
        state == BI_ACK_DECIDE && !iack_n_in && !chain_in_n_in && hit;
    endsequence

    sequence s_ack_miss;
        state == BI_ACK_DECIDE && !iack_n_in && !chain_in_n_in && !hit;
    endsequence

    sequence s_ack_release;
        state != BI_ACK_IDLE && iack_n_in;
    endsequence

    chk_chain_exclusive: assert property (@(posedge ref_clk_in) disable iff (self_reset) // [RQ4]
        answering |-> chain_out_n_out)
        else $error("chain out asserted while answering");

    chk_pass_on_miss: assert property (@(posedge ref_clk_in) disable iff (self_reset) // [RQ3]
        (state == BI_ACK_DECIDE && !iack_n_in && !chain_in_n_in && !hit) |=> !chain_out_n_out)
        else $error("acknowledge not passed on miss");

    chk_wait_chain: assert property (@(posedge ref_clk_in) disable iff (self_reset) // [RQ4]
        (state == BI_ACK_DECIDE && chain_in_n_in) |=> !answering)
        else $error("answered before chain in");

    chk_answer_on_hit: assert property (@(posedge ref_clk_in) disable iff (self_reset) // [RQ2]
        (state == BI_ACK_DECIDE && !iack_n_in && !chain_in_n_in && hit)
        |=> answering && ack_src == $past(hit_index))
        else $error("match not answered");

    chk_start_ack: assert property (@(posedge ref_clk_in) disable iff (self_reset) // [RQ1]
        (state == BI_ACK_IDLE && !iack_n_in) |=> state == BI_ACK_DECIDE)
        else $error("acknowledge start missed");

    chk_vector_data: assert property (@(posedge ref_clk_in) disable iff (self_reset) // [RQ15]
        vector_oe_out |-> !dtack_n_out && !ack_index_valid_n && vector_out == vec[ack_src])
        else $error("vector or dtack wrong");

    chk_external_quiet: assert property (@(posedge ref_clk_in) disable iff (self_reset) // [RQ20]
        (answering && ctrl[ack_src][`BI_BIT_EXT]) |-> dtack_n_out && !vector_oe_out)
        else $error("external source answered internally");

    chk_enable_gate: assert property (@(posedge ref_clk_in) disable iff (self_reset) // [RQ18]
        (!ctrl[0][`BI_BIT_ENA] && !ctrl[1][`BI_BIT_ENA] && !ctrl[2][`BI_BIT_ENA] && !ctrl[3][`BI_BIT_ENA])
        |-> bus_irq_oe_out == 7'h00)
        else $error("request without enable");

    chk_auto_clear: assert property (@(posedge ref_clk_in) disable iff (self_reset) // [RQ19]
        (entering_answer && ctrl[hit_index][`BI_BIT_ENA_CLR])
        |=> !ctrl[$past(hit_index)][`BI_BIT_ENA])
        else $error("enable not auto-cleared");

    chk_flag_clear: assert property (@(posedge ref_clk_in) disable iff (self_reset) // [RQ22]
        (entering_answer && ctrl[hit_index][`BI_BIT_FLAG_CLR])
        |=> !ctrl[$past(hit_index)][`BI_BIT_FLAG])
        else $error("flag not auto-cleared");

    chk_reset_values: assert property (@(posedge ref_clk_in) // [RQ21]
        $past(self_reset) |-> ctrl[0] == `BI_CTRL_RST && vec[3] == `BI_VEC_RST)
        else $error("reset values wrong");

    // no disable here: this check is about the reset itself
    chk_chip_reset: assert property (@(posedge ref_clk_in) // [RQ10]
        (!chip_select_n_in && !iack_n_in) |=> ctrl[2] == `BI_CTRL_RST && vec[1] == `BI_VEC_RST && state == BI_ACK_IDLE)
        else $error("select reset not applied");

    chk_seq_answer: assert property (@(posedge ref_clk_in) disable iff (self_reset) // [RQ7] [RQ8]
        s_ack_open ##1 s_ack_match |=> !ack_index_valid_n && {ack_index_bit1, ack_index_bit0} == $past(hit_index))
        else $error("index not shown on answer");

    chk_miss_quiet: assert property (@(posedge ref_clk_in) disable iff (self_reset) // [RQ3]
        s_ack_miss |=> dtack_n_out && ack_index_valid_n && !vector_oe_out)
        else $error("answered on a level miss");

    // every answer line must drop one edge after acknowledge rises
    chk_release_idle: assert property (@(posedge ref_clk_in) disable iff (self_reset) // [RQ1]
        s_ack_release |=> state == BI_ACK_IDLE && dtack_n_out && ack_index_valid_n && chain_out_n_out)
        else $error("acknowledge outputs not released");

    chk_pass_follow: assert property (@(posedge ref_clk_in) disable iff (self_reset) // [RQ3]
        (state == BI_ACK_PASS && !iack_n_in) |=> chain_out_n_out == $past(chain_in_n_in))
        else $error("chain out does not follow chain in");

    chk_index_shown: assert property (@(posedge ref_clk_in) disable iff (self_reset) // [RQ8]
        answering |-> !ack_index_valid_n && {ack_index_bit1, ack_index_bit0} == ack_src)
        else $error("index not shown while answering");

    chk_level_zero: assert property (@(posedge ref_clk_in) disable iff (self_reset) // [RQ17]
        (levels == 12'h000) |-> bus_irq_oe_out == 7'h00)
        else $error("request at level zero");

    chk_request_drive: assert property (@(posedge ref_clk_in) disable iff (self_reset) // [RQ5]
        (active[0] && levels[2:0] != 3'h0) |-> bus_irq_oe_out[levels[2:0]])
        else $error("source 0 request not driven");

    // a stuck ack would let the master retire two accesses on one answer
    chk_wb_ack_pulse: assert property (@(posedge ref_clk_in) disable iff (self_reset) // [RQ11]
        wb_ack_out |=> !wb_ack_out)
        else $error("bus ack longer than one cycle");
endmodule

// >>> test/bi_handler_model.sv
/*
 * partner model: the system interrupt handler running acknowledge cycles.
 * assumes one caller at a time and acknowledge already qualified by strobes.
 */
`timescale 1ns/1ps

module bi_handler_model (
    input wire logic ref_clk_in,
    input wire logic dtack_n_in,
    input wire logic chain_out_n_in,
    input wire logic index_valid_n_in,
    input wire logic [13:0] answer_in,
    output logic iack_n_out,
    output logic [3:1] iack_level_out,
    output logic chain_in_n_out
);
    initial begin
        iack_n_out = 1'b1;
        iack_level_out = 3'h0;
        chain_in_n_out = 1'b1;
    end

    task automatic ack_cycle(input logic [2:0] lvl, input int delay, output logic [13:0] got, output logic early);
        int n;
        early = 1'b0;
        n = 0;
        @(posedge ref_clk_in);
        iack_n_out <= 1'b0;
        iack_level_out <= lvl;
        // chain held back: any answer meanwhile is premature
        repeat (delay) begin
            @(posedge ref_clk_in);
            early = early | ~dtack_n_in | ~chain_out_n_in | ~index_valid_n_in;
        end
        chain_in_n_out <= 1'b0;
        do begin
            @(posedge ref_clk_in);
            n++;
        end while (dtack_n_in & chain_out_n_in & index_valid_n_in & (n < 10));
        got = answer_in;
        iack_n_out <= 1'b1;
        chain_in_n_out <= 1'b1;
        // released level lines show the inverse so a stale value cannot pass
        iack_level_out <= ~lvl;
        repeat (2) @(posedge ref_clk_in);
    endtask

    task automatic hold_iack(input int n);
        iack_n_out <= 1'b0;
        repeat (n) @(posedge ref_clk_in);
        iack_n_out <= 1'b1;
    endtask
endmodule

// >>> test/tb.sv
/*
 * self-checking bench for bi_core: registers, request lines, acknowledge
 * cycles through the handler model, chip-select reset.
 * assumes the handler model file is compiled alongside.
 */
`timescale 1ns/1ps
`include "bi_params.svh"

module tb;
    import bi_pkg::*;
    logic ref_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [`BI_ADDR_W-1:0] wb_adr = '0;
    logic [3:0] wb_sel = 4'hF;
    logic sel_lane0 = 1'b1;
    logic [31:0] wb_dat = 32'h0;
    logic [3:0] dev_irq_n = 4'hF;
    logic cs_n = 1'b1;
    logic wb_ack, chain_out_n, dtack_n, vec_oe, valid_n, idx0, idx1, iack_n, chain_in_n;
    logic [31:0] wb_q;
    logic [7:1] irq, irq_oe;
    logic [7:0] vec;
    logic [3:1] iack_lvl;
    logic [7:0] ctl [4];
    int mismatches = 0;
    int compares = 0;
    int cycles = 0;

    always #2.5 ref_clk_in = ~ref_clk_in;

    bi_core bi_core_i (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb),
        .wb_we_in(wb_we), .wb_adr_in(wb_adr), .wb_sel_in(wb_sel), .wb_dat_in(wb_dat), .wb_ack_out(wb_ack),
        .wb_dat_out(wb_q), .device_irq_n_in(dev_irq_n), .chip_select_n_in(cs_n), .iack_n_in(iack_n),
        .iack_level_in(iack_lvl), .chain_in_n_in(chain_in_n), .chain_out_n_out(chain_out_n),
        .bus_irq_out(irq), .bus_irq_oe_out(irq_oe), .vector_out(vec), .vector_oe_out(vec_oe),
        .dtack_n_out(dtack_n), .ack_index_valid_n(valid_n), .ack_index_bit0(idx0), .ack_index_bit1(idx1));

    bi_handler_model bi_handler_model_i (.ref_clk_in(ref_clk_in), .dtack_n_in(dtack_n),
        .chain_out_n_in(chain_out_n), .index_valid_n_in(valid_n),
        .answer_in({dtack_n, chain_out_n, valid_n, vec_oe, idx1, idx0, vec}),
        .iack_n_out(iack_n), .iack_level_out(iack_lvl), .chain_in_n_out(chain_in_n));

    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // hang guard, well above the few hundred cycles the tests need
    always @(posedge ref_clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            $display("[ERR] %0t timeout", $time);
            report_and_stop();
        end
    end

    task automatic wb(input logic we, input logic [2:0] idx, input logic [7:0] d, output logic [7:0] q);
        @(posedge ref_clk_in);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= {idx, 2'b00};
        wb_sel <= {3'($urandom), sel_lane0};
        wb_dat <= {24'h000000, d};
        do @(posedge ref_clk_in); while (wb_ack !== 1'b1);
        q = wb_q[7:0];
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask

    task automatic wr(input logic [2:0] idx, input logic [7:0] d);
        logic [7:0] q;
        wb(1'b1, idx, d, q);
        if (idx < 3'h4) ctl[idx[1:0]] = d;
    endtask

    task automatic check_reg(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t register read %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_irq(input logic [7:1] got, input logic [7:1] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t request lines %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_ack(input logic [14:0] got, input logic [14:0] exp, input logic [14:0] mask);
        compares++;
        if ((got & mask) !== (exp & mask)) begin
            mismatches++;
            $display("[ERR] %0t acknowledge answer %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_test(input string nm);
        $display("test %s done", nm);
    endtask

    function automatic logic [7:1] exp_irq(input logic [3:0] act);
        logic [7:1] r;
        r = 7'h00;
        for (int i = 0; i < 4; i++)
            if (act[i] && ctl[i][4] && ctl[i][2:0] != 3'h0) r[ctl[i][2:0]] = 1'b1;
        return r;
    endfunction

    initial begin
        logic [7:0] q, c;
        logic [7:0] v [4];
        logic [13:0] ans;
        logic [14:0] ea;
        logic early, hit;
        int s, t, w, l;
        s = $urandom(32'h19f4);
        repeat (2) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            wb(1'b0, 3'(i), 8'h00, q);
            check_reg(q, i < 4 ? `BI_CTRL_RST : `BI_VEC_RST);
        end
        end_test("reset values");
        for (int i = 0; i < 8; i++) begin
            c = 8'($urandom);
            wr(3'(i), c);
            wb(1'b0, 3'(i), 8'h00, q);
            check_reg(q, c);
        end
        // a write without byte lane 0 must leave the register alone
        sel_lane0 = 1'b0;
        wb(1'b1, 3'h0, ~ctl[0], q);
        sel_lane0 = 1'b1;
        wb(1'b0, 3'h0, 8'h00, q);
        check_reg(q, ctl[0]);
        check_irq(irq_oe | irq, 7'h00);
        end_test("register access");
        for (int i = 0; i < 32; i++) begin
            s = i / 8;
            c = {3'h0, 2'($urandom) != 2'h0, 1'b0, 3'(i)};
            wr(3'(s), c);
            dev_irq_n <= ~(4'h1 << s);
            @(posedge ref_clk_in);
            check_irq(irq_oe, exp_irq(~dev_irq_n));
        end
        dev_irq_n <= 4'hF;
        end_test("request levels");
        for (int i = 0; i < 18; i++) begin
            s = $urandom % 4;
            t = $urandom % 4;
            w = s < t ? s : t;
            l = 1 + $urandom % 7;
            hit = i % 3 != 2;
            c = {3'($urandom), 1'b1, 1'($urandom), 3'(l)};
            for (int j = 0; j < 4; j++) begin
                v[j] = 8'($urandom);
                wr(3'(j + 4), v[j]);
            end
            wr(3'(s), c);
            wr(3'(t), c);
            dev_irq_n <= ~((4'h1 << s) | (4'h1 << t));
            bi_handler_model_i.ack_cycle(hit ? 3'(l) : 3'(l % 7 + 1), $urandom % 4, ans, early);
            // early, dtack_n, chain_out_n, valid_n, vector_oe, index, vector
            ea = {1'b0, c[5], 1'b1, 1'b0, ~c[5], 2'(w), v[w]};
            if (hit)
                check_ack({early, ans}, ea, c[5] ? 15'h7F00 : 15'h7FFF);
            else
                check_ack({early, ans}, 15'h2800, 15'h7C00);
            if (hit && c[3]) ctl[w][4] = 1'b0;
            if (hit && c[6]) ctl[w][7] = 1'b0;
            wb(1'b0, 3'(w), 8'h00, q);
            check_reg(q, ctl[w]);
            check_irq(irq_oe, exp_irq(~dev_irq_n));
            dev_irq_n <= 4'hF;
        end
        end_test("acknowledge");
        wr(3'h2, 8'h97);
        dev_irq_n <= 4'hB;
        @(posedge ref_clk_in);
        check_irq(irq_oe, 7'h40);
        cs_n <= 1'b0;
        bi_handler_model_i.hold_iack(2);
        cs_n <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            wb(1'b0, 3'(i), 8'h00, q);
            check_reg(q, i < 4 ? `BI_CTRL_RST : `BI_VEC_RST);
        end
        check_irq(irq_oe, 7'h00);
        end_test("select reset");
        report_and_stop();
    end
endmodule
